// ===== tcp_core_model.sv
// Purpose: Processor-side model issuing special function register accesses.
// Assumes: Every access starts at a rising edge of CLK.
// Notes: Write data is inverted once taken, so stale data never looks valid.
`timescale 1ns/100ps
module tcp_core_model (
  input wire CLK,
  input wire [7:0] SFR_RDATA,
  output logic [7:0] SFR_ADDR,
  output logic [7:0] SFR_WDATA,
  output logic SFR_WR,
  output logic SFR_RD
);
  // ---------------------------------------------------------------------------
  // Access task
  // ---------------------------------------------------------------------------
  initial begin
    SFR_ADDR = 8'h00;
    SFR_WDATA = 8'h00;
    SFR_WR = 1'b0;
    SFR_RD = 1'b0;
  end
  // A write may be followed at once by a read of the same place; one idle edge ends each call.
  task acc(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r, output logic [7:0] q);
    begin
      q = 8'h00;
      SFR_ADDR <= a;
      if (w) begin
        SFR_WDATA <= d;
        SFR_WR <= 1'b1;
        @(posedge CLK);
        SFR_WR <= 1'b0;
        SFR_WDATA <= ~d;
      end
      if (r) begin
        SFR_RD <= 1'b1;
        @(posedge CLK);
        SFR_RD <= 1'b0;
      end
      @(posedge CLK);
      // Read data stands for the cycle after the read edge, so it is taken at this edge.
      if (r) begin
        q = SFR_RDATA;
      end
    end
  endtask
endmodule

// ===== tcp_timer_ctrl.v
// Purpose: Timer 0/1 counting core with shared clock divider configuration.
// Assumes: Special function register accesses and pins are synchronous to CLK.
// Notes:   Read data is registered and valid one cycle after the read strobe.
`timescale 1ns/100ps
`include "tcp_timer_regs.vh"

module tcp_timer_ctrl (
  input wire CLK,
  input wire SYS_RST,
  input wire [7:0] SFR_ADDR,
  input wire [7:0] SFR_WDATA,
  input wire SFR_WR,
  input wire SFR_RD,
  output reg [7:0] SFR_RDATA,
  input wire EXT_GATE_PIN_ZERO,
  input wire EXT_GATE_PIN_ONE,
  input wire COUNT_PIN_ZERO,
  input wire COUNT_PIN_ONE,
  input wire TIMER2_BAUD_OR_CLKOUT,
  input wire XMOVE_INTERNAL,
  output reg INSTR_TICK,
  output reg TIMER2_TICK,
  output reg TIMER0_OVERFLOW,
  output reg TIMER1_OVERFLOW,
  output reg [3:0] XMOVE_CYCLES,
  output reg [4:0] XMOVE_STROBE_CLKS
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function [4:0] strobe_clks;
    input [2:0] stretch;
    begin
      if (stretch == 3'd0) begin
        strobe_clks = `TCP_MOVE_BASE_STROBE;
      end else begin
        strobe_clks = {2'b00, stretch} * `TCP_STROBE_PER_STEP;
      end
    end
  endfunction

  function timer_enable;
    input run;
    input gated;
    input gate_pin;
    begin
      timer_enable = run & (~gated | gate_pin);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg [7:0] run_ctrl_q;
  reg [7:0] run_ctrl_d;
  reg [7:0] mode_sel_q;
  reg [7:0] clk_cfg_q;
  reg [3:0] presc_q;
  reg cpin0_q;
  reg cpin1_q;

  wire [7:0] t0_lo;
  wire [7:0] t0_hi;
  wire [7:0] t1_lo;
  wire [7:0] t1_hi;
  wire t0_ovf_lo;
  wire t0_ovf_hi;
  wire t1_ovf_lo;
  wire t1_ovf_hi;

  wire wr_run = SFR_WR & (SFR_ADDR == `TCP_ADDR_RUN_CONTROL);
  wire wr_mode = SFR_WR & (SFR_ADDR == `TCP_ADDR_MODE_SELECT);
  wire wr_cfg = SFR_WR & (SFR_ADDR == `TCP_ADDR_CLOCK_CONFIG);

  // --------------------------------------------------------------------------
  // Prescaler
  // --------------------------------------------------------------------------
  // One free-running divider serves every rate, so the instruction tick never
  // depends on the clock select bits and timers keep a fixed cadence.
  wire tick_slow = (presc_q == `TCP_DIV_SLOW - 4'd1);
  wire tick_fast = (presc_q[1:0] == 2'b11);

  always @(posedge CLK) begin
    if (SYS_RST) begin
      presc_q <= 4'h0;
    end else if (tick_slow) begin
      presc_q <= 4'h0;
    end else begin
      presc_q <= presc_q + 4'd1;
    end
  end

  wire t0_rate = clk_cfg_q[`TCP_CFG_T0_FAST] ? tick_fast : tick_slow;
  wire t1_rate = clk_cfg_q[`TCP_CFG_T1_FAST] ? tick_fast : tick_slow;
  // In baud or clock output mode timer 2 gets its clock elsewhere; the select is ignored.
  wire t2_fast = clk_cfg_q[`TCP_CFG_T2_FAST] & ~TIMER2_BAUD_OR_CLKOUT;

  // --------------------------------------------------------------------------
  // Count events
  // --------------------------------------------------------------------------
  always @(posedge CLK) begin
    if (SYS_RST) begin
      cpin0_q <= 1'b0;
      cpin1_q <= 1'b0;
    end else begin
      cpin0_q <= COUNT_PIN_ZERO;
      cpin1_q <= COUNT_PIN_ONE;
    end
  end

  wire fall0 = cpin0_q & ~COUNT_PIN_ZERO;
  wire fall1 = cpin1_q & ~COUNT_PIN_ONE;
  wire ev0 = mode_sel_q[`TCP_MODE_T0_CT] ? fall0 : t0_rate;
  wire ev1 = mode_sel_q[`TCP_MODE_T1_CT] ? fall1 : t1_rate;

  wire en0 = timer_enable(run_ctrl_q[`TCP_RUN_T0_RUN], mode_sel_q[`TCP_MODE_T0_GATE],
                          EXT_GATE_PIN_ZERO);
  wire en1 = timer_enable(run_ctrl_q[`TCP_RUN_T1_RUN], mode_sel_q[`TCP_MODE_T1_GATE],
                          EXT_GATE_PIN_ONE);

  wire [1:0] mode0 = mode_sel_q[`TCP_MODE_T0_HI:`TCP_MODE_T0_LO];
  wire [1:0] mode1 = mode_sel_q[`TCP_MODE_T1_HI:`TCP_MODE_T1_LO];
  wire split0 = (mode0 == `TCP_MODE_SPLIT);

  wire inc0_lo = en0 & ev0;
  // In split mode the high byte of timer 0 borrows timer 1's run bit.
  wire inc0_hi = split0 & run_ctrl_q[`TCP_RUN_T1_RUN] & t0_rate;
  wire inc1 = (mode1 != `TCP_MODE_SPLIT) & en1 & ev1;

  // --------------------------------------------------------------------------
  // Count value pairs
  // --------------------------------------------------------------------------
  tcp_timer_unit u_timer0 (
    .clk(CLK),
    .rst(SYS_RST),
    .mode(mode0),
    .inc_lo(inc0_lo),
    .inc_hi(inc0_hi),
    .wr_lo(SFR_WR & (SFR_ADDR == `TCP_ADDR_T0_LOW)),
    .wr_hi(SFR_WR & (SFR_ADDR == `TCP_ADDR_T0_HIGH)),
    .wdata(SFR_WDATA),
    .lo_q(t0_lo),
    .hi_q(t0_hi),
    .ovf_lo(t0_ovf_lo),
    .ovf_hi(t0_ovf_hi)
  );

  tcp_timer_unit u_timer1 (
    .clk(CLK),
    .rst(SYS_RST),
    .mode(mode1),
    .inc_lo(inc1),
    .inc_hi(1'b0),
    .wr_lo(SFR_WR & (SFR_ADDR == `TCP_ADDR_T1_LOW)),
    .wr_hi(SFR_WR & (SFR_ADDR == `TCP_ADDR_T1_HIGH)),
    .wdata(SFR_WDATA),
    .lo_q(t1_lo),
    .hi_q(t1_hi),
    .ovf_lo(t1_ovf_lo),
    .ovf_hi(t1_ovf_hi)
  );

  // --------------------------------------------------------------------------
  // Shared control and mode registers
  // --------------------------------------------------------------------------
  // A hardware overflow in the same cycle as a software write still sets the flag.
  always @* begin
    run_ctrl_d = run_ctrl_q;
    if (wr_run) begin
      run_ctrl_d = SFR_WDATA;
    end
    if (t0_ovf_lo) begin
      run_ctrl_d[`TCP_RUN_T0_OVF] = 1'b1;
    end
    if (split0 ? t0_ovf_hi : (t1_ovf_lo | t1_ovf_hi)) begin
      run_ctrl_d[`TCP_RUN_T1_OVF] = 1'b1;
    end
  end

  always @(posedge CLK) begin
    if (SYS_RST) begin
      run_ctrl_q <= `TCP_RST_RUN_CONTROL;
      mode_sel_q <= `TCP_RST_MODE_SELECT;
      clk_cfg_q <= `TCP_RST_CLOCK_CONFIG;
    end else begin
      run_ctrl_q <= run_ctrl_d;
      if (wr_mode) begin
        mode_sel_q <= SFR_WDATA;
      end
      if (wr_cfg) begin
        clk_cfg_q <= SFR_WDATA & `TCP_CFG_WRITE_MASK;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register read
  // --------------------------------------------------------------------------
  reg [7:0] rd_mux;

  always @* begin
    case (SFR_ADDR)
      `TCP_ADDR_RUN_CONTROL: rd_mux = run_ctrl_q;
      `TCP_ADDR_MODE_SELECT: rd_mux = mode_sel_q;
      `TCP_ADDR_T0_LOW: rd_mux = t0_lo;
      `TCP_ADDR_T1_LOW: rd_mux = t1_lo;
      `TCP_ADDR_T0_HIGH: rd_mux = t0_hi;
      `TCP_ADDR_T1_HIGH: rd_mux = t1_hi;
      `TCP_ADDR_CLOCK_CONFIG: rd_mux = clk_cfg_q & `TCP_CFG_WRITE_MASK;
      default: rd_mux = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------------
  wire [2:0] stretch = clk_cfg_q[`TCP_CFG_STRETCH_HI:`TCP_CFG_STRETCH_LO];

  always @(posedge CLK) begin
    if (SYS_RST) begin
      SFR_RDATA <= 8'h00;
      INSTR_TICK <= 1'b0;
      TIMER2_TICK <= 1'b0;
      TIMER0_OVERFLOW <= 1'b0;
      TIMER1_OVERFLOW <= 1'b0;
      XMOVE_CYCLES <= `TCP_MOVE_BASE_CYCLES;
      XMOVE_STROBE_CLKS <= `TCP_MOVE_BASE_STROBE;
    end else begin
      SFR_RDATA <= SFR_RD ? rd_mux : 8'h00;
      INSTR_TICK <= tick_fast;
      TIMER2_TICK <= t2_fast ? tick_fast : tick_slow;
      TIMER0_OVERFLOW <= run_ctrl_q[`TCP_RUN_T0_OVF];
      TIMER1_OVERFLOW <= run_ctrl_q[`TCP_RUN_T1_OVF];
      if (XMOVE_INTERNAL) begin
        XMOVE_CYCLES <= `TCP_MOVE_BASE_CYCLES;
        XMOVE_STROBE_CLKS <= `TCP_MOVE_BASE_STROBE;
      end else begin
        XMOVE_CYCLES <= `TCP_MOVE_BASE_CYCLES + {1'b0, stretch};
        XMOVE_STROBE_CLKS <= strobe_clks(stretch);
      end
    end
  end

endmodule

// ===== tcp_timer_ctrl_sva.sv
// Purpose: Port checks for the timer clock and prescale controller.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Bound to every tcp_timer_ctrl instance.
`timescale 1ns/100ps
module tcp_timer_ctrl_sva (
  input wire CLK,
  input wire SYS_RST,
  input wire [7:0] SFR_ADDR,
  input wire [7:0] SFR_WDATA,
  input wire SFR_WR,
  input wire SFR_RD,
  input wire [7:0] SFR_RDATA,
  input wire TIMER2_BAUD_OR_CLKOUT,
  input wire XMOVE_INTERNAL,
  input wire INSTR_TICK,
  input wire TIMER2_TICK,
  input wire TIMER0_OVERFLOW,
  input wire TIMER1_OVERFLOW,
  input wire [3:0] XMOVE_CYCLES,
  input wire [4:0] XMOVE_STROBE_CLKS
);
  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  wire [2:0] wr_stretch = SFR_WDATA[2:0];
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  property p_internal;
    XMOVE_INTERNAL |=> XMOVE_CYCLES == 4'h2 && XMOVE_STROBE_CLKS == 5'h02;
  endproperty
  a_internal: assert property (p_internal) else $error("internal move not short");
  property p_strobe;
    XMOVE_STROBE_CLKS == ((XMOVE_CYCLES == 4'h2) ? 5'h02 : {XMOVE_CYCLES[2:0] - 3'h2, 2'b00});
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe width mismatch");
  // The output lags the register by one edge, so the check looks two edges back.
  property p_cfg;
    (SFR_WR && SFR_ADDR == 8'h8E) ##1 !XMOVE_INTERNAL |=> XMOVE_CYCLES == {1'b0, $past(wr_stretch, 2)} + 4'h2;
  endproperty
  a_cfg: assert property (p_cfg) else $error("move cycles mismatch");
  property p_itick;
    INSTR_TICK |=> !INSTR_TICK [*3] ##1 INSTR_TICK;
  endproperty
  a_itick: assert property (p_itick) else $error("instruction tick period");
  property p_t2baud;
    // The tick is registered, so baud mode must already be seen one edge before it.
    TIMER2_BAUD_OR_CLKOUT ##1 TIMER2_TICK && TIMER2_BAUD_OR_CLKOUT ##1
      TIMER2_BAUD_OR_CLKOUT [*3] |=> !TIMER2_TICK;
  endproperty
  a_t2baud: assert property (p_t2baud) else $error("timer 2 fast in baud mode");
  property p_cfgtop;
    SFR_RD && SFR_ADDR == 8'h8E |=> SFR_RDATA[7:6] == 2'b00;
  endproperty
  a_cfgtop: assert property (p_cfgtop) else $error("config top bits set");
  property p_unmapped;
    SFR_RD && (SFR_ADDR < 8'h88 || SFR_ADDR > 8'h8E) |=> SFR_RDATA == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ovf;
    SFR_RD && SFR_ADDR == 8'h88 |=> SFR_RDATA[7] == TIMER1_OVERFLOW && SFR_RDATA[5] == TIMER0_OVERFLOW;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow output differs from flag");
endmodule
bind tcp_timer_ctrl tcp_timer_ctrl_sva chk_u (.CLK(CLK), .SYS_RST(SYS_RST), .SFR_ADDR(SFR_ADDR),
  .SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA),
  .TIMER2_BAUD_OR_CLKOUT(TIMER2_BAUD_OR_CLKOUT), .XMOVE_INTERNAL(XMOVE_INTERNAL),
  .INSTR_TICK(INSTR_TICK), .TIMER2_TICK(TIMER2_TICK), .TIMER0_OVERFLOW(TIMER0_OVERFLOW),
  .TIMER1_OVERFLOW(TIMER1_OVERFLOW), .XMOVE_CYCLES(XMOVE_CYCLES), .XMOVE_STROBE_CLKS(XMOVE_STROBE_CLKS));

// ===== tcp_timer_regs.vh
// Purpose: Register offsets, field positions, reset values and timing counts
//          for the timer clock and prescale controller.
// Assumes: Registers sit in an 8-bit special function register space.
// Notes:   Definitions only.

`ifndef TCP_TIMER_REGS_VH
`define TCP_TIMER_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define TCP_ADDR_RUN_CONTROL 8'h88
`define TCP_ADDR_MODE_SELECT 8'h89
`define TCP_ADDR_T0_LOW 8'h8A
`define TCP_ADDR_T1_LOW 8'h8B
`define TCP_ADDR_T0_HIGH 8'h8C
`define TCP_ADDR_T1_HIGH 8'h8D
`define TCP_ADDR_CLOCK_CONFIG 8'h8E

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TCP_RST_RUN_CONTROL 8'h00
`define TCP_RST_MODE_SELECT 8'h00
`define TCP_RST_COUNT 8'h00
`define TCP_RST_CLOCK_CONFIG 8'h01

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TCP_RUN_T1_OVF 7
`define TCP_RUN_T1_RUN 6
`define TCP_RUN_T0_OVF 5
`define TCP_RUN_T0_RUN 4
`define TCP_MODE_T1_GATE 7
`define TCP_MODE_T1_CT 6
`define TCP_MODE_T1_HI 5
`define TCP_MODE_T1_LO 4
`define TCP_MODE_T0_GATE 3
`define TCP_MODE_T0_CT 2
`define TCP_MODE_T0_HI 1
`define TCP_MODE_T0_LO 0
`define TCP_CFG_T2_FAST 5
`define TCP_CFG_T1_FAST 4
`define TCP_CFG_T0_FAST 3
`define TCP_CFG_STRETCH_HI 2
`define TCP_CFG_STRETCH_LO 0
`define TCP_CFG_WRITE_MASK 8'h3F

// ----------------------------------------------------------------------------
// Timer modes and timing counts
// ----------------------------------------------------------------------------
`define TCP_MODE_13BIT 2'b00
`define TCP_MODE_16BIT 2'b01
`define TCP_MODE_RELOAD 2'b10
`define TCP_MODE_SPLIT 2'b11
`define TCP_DIV_SLOW 4'd12
`define TCP_DIV_FAST 4'd4
`define TCP_MOVE_BASE_CYCLES 4'd2
`define TCP_MOVE_BASE_STROBE 5'd2
`define TCP_STROBE_PER_STEP 5'd4

`endif

// ===== tcp_timer_unit.v
// Purpose: Count value pair of one timer, stepping per the selected mode.
// Assumes: Increment requests are single-cycle strobes from the controller.
// Notes:   Software writes win over an increment of the same byte.
`timescale 1ns/100ps
`include "tcp_timer_regs.vh"

module tcp_timer_unit (
  input wire clk,
  input wire rst,
  input wire [1:0] mode,
  input wire inc_lo,
  input wire inc_hi,
  input wire wr_lo,
  input wire wr_hi,
  input wire [7:0] wdata,
  output reg [7:0] lo_q,
  output reg [7:0] hi_q,
  output reg ovf_lo,
  output reg ovf_hi
);

  reg [7:0] lo_d;
  reg [7:0] hi_d;

  // --------------------------------------------------------------------------
  // Next count
  // --------------------------------------------------------------------------
  always @* begin
    lo_d = lo_q;
    hi_d = hi_q;
    ovf_lo = 1'b0;
    ovf_hi = 1'b0;
    case (mode)
      `TCP_MODE_13BIT: begin
        // The upper three low-byte bits are left untouched; software masks them.
        if (inc_lo) begin
          lo_d = {lo_q[7:5], lo_q[4:0] + 5'd1};
          if (lo_q[4:0] == 5'h1F) begin
            hi_d = hi_q + 8'd1;
            ovf_lo = (hi_q == 8'hFF);
          end
        end
      end
      `TCP_MODE_16BIT: begin
        if (inc_lo) begin
          {hi_d, lo_d} = {hi_q, lo_q} + 16'h0001;
          ovf_lo = ({hi_q, lo_q} == 16'hFFFF);
        end
      end
      `TCP_MODE_RELOAD: begin
        if (inc_lo) begin
          lo_d = (lo_q == 8'hFF) ? hi_q : lo_q + 8'd1;
          ovf_lo = (lo_q == 8'hFF);
        end
      end
      `TCP_MODE_SPLIT: begin
        if (inc_lo) begin
          lo_d = lo_q + 8'd1;
          ovf_lo = (lo_q == 8'hFF);
        end
        if (inc_hi) begin
          hi_d = hi_q + 8'd1;
          ovf_hi = (hi_q == 8'hFF);
        end
      end
      default: begin
        lo_d = lo_q;
      end
    endcase
    if (wr_lo) begin
      lo_d = wdata;
    end
    if (wr_hi) begin
      hi_d = wdata;
    end
  end

  // --------------------------------------------------------------------------
  // Count registers
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      lo_q <= `TCP_RST_COUNT;
      hi_q <= `TCP_RST_COUNT;
    end else begin
      lo_q <= lo_d;
      hi_q <= hi_d;
    end
  end

endmodule

// ===== testbench.sv
// Purpose: Self-checking bench for the timer clock and prescale controller.
// Assumes: The core model issues every register access.
// Notes: Count windows are multiples of the tick period, so tick phase never matters.
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic g0 = 1'b0;
  logic c0 = 1'b0;
  logic baud = 1'b0;
  logic xint = 1'b0;
  logic cnt_en = 1'b0;
  logic [7:0] n_t2 = 8'h00, n_in = 8'h00, b_t2, b_in, q;
  wire [7:0] addr, wdata, rdata;
  wire s_wr, s_rd, itick, t2tick, ov0, ov1;
  wire [3:0] xcyc;
  wire [4:0] xstb;
  int i, j;
  int n_errors = 0;
  int tests_run = 0;
  // ---------------------------------------------------------------------------
  // Harness
  // ---------------------------------------------------------------------------
  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (cnt_en) begin
      n_t2 <= n_t2 + {7'h00, t2tick};
      n_in <= n_in + {7'h00, itick};
    end
  end
  tcp_timer_ctrl dut_u (.CLK(clk), .SYS_RST(rst), .SFR_ADDR(addr), .SFR_WDATA(wdata), .SFR_WR(s_wr),
    .SFR_RD(s_rd), .SFR_RDATA(rdata), .EXT_GATE_PIN_ZERO(g0), .EXT_GATE_PIN_ONE(1'b0),
    .COUNT_PIN_ZERO(c0), .COUNT_PIN_ONE(1'b0), .TIMER2_BAUD_OR_CLKOUT(baud), .XMOVE_INTERNAL(xint),
    .INSTR_TICK(itick), .TIMER2_TICK(t2tick), .TIMER0_OVERFLOW(ov0), .TIMER1_OVERFLOW(ov1),
    .XMOVE_CYCLES(xcyc), .XMOVE_STROBE_CLKS(xstb));
  tcp_core_model core_u (.CLK(clk), .SFR_RDATA(rdata), .SFR_ADDR(addr), .SFR_WDATA(wdata),
    .SFR_WR(s_wr), .SFR_RD(s_rd));
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task put(input logic [7:0] a, input logic [7:0] d);
    core_u.acc(a, d, 1'b1, 1'b0, q);
  endtask
  task chk(input logic [7:0] a, input logic [7:0] e);
    begin
      core_u.acc(a, 8'h00, 1'b0, 1'b1, q);
      cmp(q, e);
    end
  endtask
  // Runs with the given run bits for exactly n count edges.
  task win(input logic [7:0] run, input int n);
    begin
      put(8'h88, run);
      repeat (n - 2) @(posedge clk);
      put(8'h88, 8'h00);
    end
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task t_reset;
    begin
      for (i = 0; i < 6; i = i + 1) chk(8'h88 + i[7:0], 8'h00);
      chk(8'h8E, 8'h01);
      cmp({4'h0, xcyc}, 8'h03);
      cmp({3'h0, xstb}, 8'h04);
    end
  endtask
  task t_cfg;
    begin
      put(8'h8E, 8'hFF);
      chk(8'h8E, 8'h3F);
      put(8'h90, 8'h5A);
      chk(8'h90, 8'h00);
      for (i = 0; i < 8; i = i + 1) begin
        put(8'h8E, i[7:0]);
        #1;
        cmp({4'h0, xcyc}, i[7:0] + 8'h02);
        cmp({3'h0, xstb}, (i == 0) ? 8'h02 : {i[5:0], 2'b00});
        @(posedge clk);
      end
      xint <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      cmp({4'h0, xcyc}, 8'h02);
      cmp({3'h0, xstb}, 8'h02);
      @(posedge clk);
      xint <= 1'b0;
    end
  endtask
  // Both timers run together under every mix of their fast bits, timer 2's tied to timer 1's; the last pass adds baud mode.
  task t_rate;
    begin
      core_u.acc(8'h89, 8'h11, 1'b1, 1'b1, q);
      cmp(q, 8'h11);
      for (i = 0; i < 4; i = i + 1) begin
        baud <= (i == 3);
        put(8'h8E, {2'b00, i[1], i[1], i[0], 3'b001});
        for (j = 0; j < 4; j = j + 1) put(8'h8A + j[7:0], 8'h00);
        b_t2 = n_t2;
        b_in = n_in;
        put(8'h88, 8'h50);
        cnt_en <= 1'b1;
        repeat (46) @(posedge clk);
        put(8'h88, 8'h00);
        cnt_en <= 1'b0;
        chk(8'h8A, i[0] ? 8'h0C : 8'h04);
        chk(8'h8B, i[1] ? 8'h0C : 8'h04);
        chk(8'h8C, 8'h00);
        cmp(n_t2 - b_t2, (i == 2) ? 8'h0C : 8'h04);
        cmp(n_in - b_in, 8'h0C);
      end
      baud <= 1'b0;
    end
  endtask
  task t_wrap;
    begin
      put(8'h8E, 8'h09);
      put(8'h8A, 8'hFF);
      put(8'h8C, 8'hFF);
      put(8'h88, 8'h10);
      repeat (6) @(posedge clk);
      put(8'h89, 8'h19);
      chk(8'h8A, 8'h01);
      chk(8'h8C, 8'h00);
      chk(8'h88, 8'h30);
      cmp({7'h00, ov0}, 8'h01);
      g0 <= 1'b1;
      repeat (8) @(posedge clk);
      g0 <= 1'b0;
      chk(8'h8A, 8'h03);
      put(8'h88, 8'h00);
    end
  endtask
  task t_modes;
    begin
      put(8'h8E, 8'h19);
      put(8'h89, 8'h12);
      put(8'h8C, 8'hFD);
      put(8'h8A, 8'hFE);
      win(8'h10, 8);
      chk(8'h8A, 8'hFD);
      put(8'h89, 8'h10);
      put(8'h8C, 8'h00);
      put(8'h8A, 8'h1F);
      win(8'h10, 4);
      chk(8'h8A, 8'h00);
      chk(8'h8C, 8'h01);
      put(8'h89, 8'h30);
      put(8'h8B, 8'h00);
      win(8'h40, 8);
      chk(8'h8B, 8'h00);
      put(8'h89, 8'h15);
      put(8'h8A, 8'h00);
      put(8'h88, 8'h10);
      for (i = 0; i < 5; i = i + 1) begin
        c0 <= 1'b1;
        @(posedge clk);
        c0 <= 1'b0;
        @(posedge clk);
      end
      chk(8'h8A, 8'h05);
    end
  endtask
  // Timer 0 split in two byte counters; its high byte runs on timer 1's run bit and flag.
  task t_split;
    begin
      put(8'h88, 8'h00);
      put(8'h89, 8'h03);
      put(8'h8A, 8'hFF);
      put(8'h8C, 8'hFF);
      put(8'h88, 8'h50);
      repeat (4) @(posedge clk);
      chk(8'h88, 8'hF0);
      cmp({7'h00, ov1}, 8'h01);
      put(8'h88, 8'h00);
      chk(8'h8A, 8'h01);
      chk(8'h8C, 8'h01);
    end
  endtask
  task results;
    begin
      $display("mismatches=%0d compares=%0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_cfg;
    t_rate;
    t_wrap;
    t_modes;
    t_split;
    results;
  end
  // The whole sequence needs a few hundred cycles; this limit is far beyond it.
  initial begin
    #100000;
    n_errors = n_errors + 1;
    results;
  end
endmodule
